// ===== inc/lipu_pkg.sv
// Shared constants and types of the last-in pop unit.
`default_nettype none
package lipu_pkg;
  // ==========================================================================
  // Table geometry.
  // ==========================================================================
  // Width of every table word and of the destination word.
  localparam int LIPU_WORD_W = 16;
  // Allowed table length, pointer word included.
  localparam int LIPU_TBL_MIN = 2;
  localparam int LIPU_TBL_MAX = 512;
  // Offset of the pointer word and of the first data word.
  localparam int LIPU_PTR_OFS = 0;
  localparam int LIPU_DATA_OFS = 1;
  // Step applied to the pointer by one pop or one shift-write.
  localparam logic [15:0] LIPU_PTR_STEP = 16'h0001;
  // ==========================================================================
  // Values after reset and error code.
  // ==========================================================================
  localparam logic [15:0] LIPU_PTR_RST = 16'h0000;
  localparam logic [15:0] LIPU_WORD_RST = 16'h0000;
  // Range error code, decimal 6706.
  localparam logic [15:0] LIPU_ERR_RANGE = 16'h1a32;
  // ==========================================================================
  // Buffering.
  // ==========================================================================
  localparam int LIPU_FIFO_DEPTH = 8;
  // Outcome of one operation cycle.
  typedef enum logic [1:0] {
    LIPU_RES_NONE = 2'b00,
    LIPU_RES_POP = 2'b01,
    LIPU_RES_EMPTY = 2'b10,
    LIPU_RES_ERR = 2'b11
  } lipu_res_t;
endpackage
`default_nettype wire

// ===== inc/lipu_fifo_if.sv
// Handshake bundle between the pop unit and its output FIFO.
`default_nettype none
interface lipu_fifo_if #(parameter int WIDTH = 16);
  // Fill side, driven by the pop logic.
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  // Drain side, facing the consumer of popped words.
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  // The pop logic fills and drains through the top ports.
  modport fill (output wr_valid, output wr_data, input wr_ready,
                input rd_valid, input rd_data, output rd_ready);
  // The FIFO itself.
  modport store (input wr_valid, input wr_data, output wr_ready,
                 output rd_valid, output rd_data, input rd_ready);
endinterface
`default_nettype wire

// ===== design/lipu_fifo.sv
// Small synchronous FIFO holding popped words for the consumer.
`default_nettype none
module lipu_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and synchronised reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Both handshake sides.
  lipu_fifo_if.store q
);
  // ==========================================================================
  // Checks and storage.
  // ==========================================================================
  localparam int AW = $clog2(DEPTH);
  // Pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 2 || (2 ** AW) != DEPTH) begin : g_bad_depth
    $error("lipu_fifo: DEPTH must be a power of two of at least 2.");
  end
  logic [WIDTH-1:0] mem [DEPTH]; // Word storage, not reset.
  logic [AW-1:0] wr_ptr; // Next slot to fill.
  logic [AW-1:0] rd_ptr; // Oldest stored slot.
  logic [AW:0] count; // Words held.
  logic [AW:0] next_count; // Words held after this cycle.
  logic room; // Registered not-full.
  logic filled; // Registered not-empty.
  logic push; // A word enters.
  logic pop; // A word leaves.

  assign push = q.wr_valid && room;
  assign pop = filled && q.rd_ready;
  assign q.wr_ready = room;
  assign q.rd_valid = filled;
  assign q.rd_data = mem[rd_ptr];

  // ==========================================================================
  // Occupancy.
  // ==========================================================================
  // Next count; a push and a pop in one cycle cancel.
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW + 1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW + 1)'(1);
    end
  end

  // Flags are registered from the next count so both stay honest.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
      room <= 1'b1;
      filled <= 1'b0;
    end else begin
      count <= next_count;
      room <= next_count != (AW + 1)'(DEPTH);
      filled <= next_count != '0;
    end
  end

  // Pointers advance on each accepted transfer.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  // Storage write.
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= q.wr_data;
    end
  end
endmodule
`default_nettype wire

// ===== design/lipu_pop_unit.sv
// Last-in pop unit: table of a pointer word and data words, popped last first.
// How it works
// [R1] Pointer word first, data at offsets one onward.
// [R2] Pop copies word at base plus pointer.
// [R3] Table length must lie in two..512.
// [R4] Successful pop decrements the pointer by one.
// [R5] Pointer zero: zero flag, no read, no update.
// [R6] Pointer one: pointer becomes zero, zero flag.
// [R7] Pointer above length minus one: error 6706.
// [R8] Negative pointer: error 6706.
// [R9] Errors set error flag and store code.
// [R10] Continuous pops each cycle; pulse pops once. Code holds every pop while the output FIFO is full.
// [R11] Requester checks pointer range before popping.
// [R12] Length counts entries plus the pointer word.
// [R13] Pop returns the latest shift-written entry.
// [R14] Pop never alters the data words.
// [R15] Execution state high when enabled pop processed.
`default_nettype none
module lipu_pop_unit
  import lipu_pkg::*;
#(
  parameter int TABLE_DEPTH = LIPU_TBL_MAX
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Pop command.
  input wire logic enable_i,
  input wire logic pulse_mode_i,
  input wire logic [15:0] table_len_i,
  // Companion shift-write and pointer load.
  input wire logic shift_write_entry_i,
  input wire logic [15:0] write_data_i,
  input wire logic ptr_load_i,
  input wire logic [15:0] ptr_load_value_i,
  // Error flag clear.
  input wire logic error_clear_i,
  // Popped word stream.
  output logic out_valid_o,
  output logic [15:0] out_data_o,
  input wire logic out_ready_i,
  // Status.
  output logic [15:0] dest_word_o,
  output logic [15:0] pointer_o,
  output logic [15:0] error_code_word_o,
  output logic zero_flag_o,
  output logic operation_error_flag_o,
  output logic execution_state_out_o
);
  // ==========================================================================
  // Checks and declarations.
  // ==========================================================================
  localparam int IW = $clog2(TABLE_DEPTH);
  if (TABLE_DEPTH < LIPU_TBL_MIN || TABLE_DEPTH > LIPU_TBL_MAX) begin : g_bad
    $error("lipu_pop_unit: TABLE_DEPTH must lie in 2..512.");
  end
  // Data words; slot zero is unused because the pointer lives in ptr.
  logic [15:0] mem [TABLE_DEPTH];
  logic rst_meta; // First reset release stage.
  logic rst_b; // Synchronised reset, used everywhere.
  logic [15:0] ptr; // The pointer word.
  logic [15:0] len_m1; // Highest legal pointer.
  logic [15:0] len_m2; // Highest pointer that still accepts a write.
  logic len_bad; // Table length out of range.
  logic en_done; // Pulse form already served in this activation.
  logic req; // A pop is requested this cycle.
  logic take; // The request is processed this cycle.
  logic push_ok; // A shift-write is stored this cycle.
  logic [15:0] rd_word; // Word addressed by the pointer.
  lipu_res_t res; // Outcome of this cycle.
  lipu_fifo_if #(.WIDTH(LIPU_WORD_W)) f ();

  // Nonnegative and not above the limit, in two's complement.
  function automatic logic lipu_fits(input logic [15:0] v,
                                     input logic [15:0] lim);
    return !v[15] && (v <= lim);
  endfunction

  // ==========================================================================
  // Reset release.
  // ==========================================================================
  // Release passes two flops so every process leaves reset on one edge.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_b <= rst_meta;
    end
  end

  // ==========================================================================
  // Request and classification.
  // ==========================================================================
  assign len_m1 = table_len_i - LIPU_PTR_STEP; // [R12]
  assign len_m2 = len_m1 - LIPU_PTR_STEP;
  assign len_bad = table_len_i < 16'(LIPU_TBL_MIN) ||
                   table_len_i > 16'(TABLE_DEPTH); // [R3]
  // Continuous form asks every cycle, pulse form once per activation.
  assign req = enable_i && (!pulse_mode_i || !en_done); // [R10]
  assign rd_word = mem[ptr[IW-1:0]]; // [R2]
  assign take = res != LIPU_RES_NONE;

  // A full FIFO stalls every outcome, so no pop is ever dropped.
  always_comb begin
    res = LIPU_RES_NONE;
    if (req && f.wr_ready) begin
      if (len_bad || !lipu_fits(ptr, len_m1)) begin
        res = LIPU_RES_ERR; // [R7] [R8]
      end else if (ptr == LIPU_PTR_RST) begin
        res = LIPU_RES_EMPTY; // [R5]
      end else begin
        res = LIPU_RES_POP;
      end
    end
  end

  // Pulse bookkeeping: cleared only when the enable falls.
  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      en_done <= 1'b0;
    end else if (!enable_i) begin
      en_done <= 1'b0;
    end else if (take) begin
      en_done <= 1'b1; // [R10]
    end
  end

  // ==========================================================================
  // Table update.
  // ==========================================================================
  // A shift-write yields to a pop in the same cycle, which keeps the
  // popped word and the data words untouched by that pop.
  assign push_ok = shift_write_entry_i && !take && !ptr_load_i &&
                   !len_bad && lipu_fits(ptr, len_m2); // [R14]

  // Pointer word: load, pop decrement, or shift-write increment.
  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= LIPU_PTR_RST;
    end else if (ptr_load_i) begin
      ptr <= ptr_load_value_i;
    end else begin
      case (res)
        LIPU_RES_POP: begin
          ptr <= ptr - LIPU_PTR_STEP; // [R4] [R6]
        end
        default: begin
          if (push_ok) begin
            ptr <= ptr + LIPU_PTR_STEP; // [R1]
          end
        end
      endcase
    end
  end

  // Data words fill upward from the first data offset.
  always_ff @(posedge clk_sys_i) begin
    if (push_ok) begin
      mem[IW'(ptr + LIPU_PTR_STEP)] <= write_data_i; // [R1] [R13]
    end
  end

  // ==========================================================================
  // Results.
  // ==========================================================================
  // Destination word takes the newest entry on each pop.
  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      dest_word_o <= LIPU_WORD_RST;
    end else if (res == LIPU_RES_POP) begin
      dest_word_o <= rd_word; // [R2] [R13]
    end
  end

  // Zero flag follows the latest pop or empty outcome; an error outcome leaves it unchanged.
  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      zero_flag_o <= 1'b0;
    end else if (res == LIPU_RES_EMPTY) begin
      zero_flag_o <= 1'b1; // [R5]
    end else if (res == LIPU_RES_POP) begin
      zero_flag_o <= ptr == LIPU_PTR_STEP; // [R6]
    end
  end

  // Error flag is sticky; a new error beats a clear in the same cycle.
  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      operation_error_flag_o <= 1'b0;
      error_code_word_o <= LIPU_WORD_RST;
    end else if (res == LIPU_RES_ERR) begin
      operation_error_flag_o <= 1'b1; // [R9]
      error_code_word_o <= LIPU_ERR_RANGE; // [R9]
    end else if (error_clear_i) begin
      operation_error_flag_o <= 1'b0;
    end
  end

  // Execution state marks each processed request.
  always_ff @(posedge clk_sys_i or negedge rst_b) begin
    if (!rst_b) begin
      execution_state_out_o <= 1'b0;
    end else begin
      execution_state_out_o <= take; // [R15]
    end
  end

  assign pointer_o = ptr;
  assign f.wr_valid = res == LIPU_RES_POP;
  assign f.wr_data = rd_word;
  assign f.rd_ready = out_ready_i;
  assign out_valid_o = f.rd_valid;
  assign out_data_o = f.rd_data;

  // Output buffer; its ready stalls the pop logic when full.
  lipu_fifo #(.WIDTH(LIPU_WORD_W), .DEPTH(LIPU_FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b),
    .q(f)
  );

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b);

  AST_POP_DATA: assert property ( // [R2]
    res == LIPU_RES_POP |=> dest_word_o == $past(rd_word))
    else $error("Popped word not copied to destination.");
  AST_LEN_ERR: assert property ( // [R3]
    req && f.wr_ready && len_bad |=> operation_error_flag_o)
    else $error("Bad table length not flagged.");
  AST_POP_DEC: assert property ( // [R4]
    res == LIPU_RES_POP && !ptr_load_i |=>
      ptr == 16'($past(ptr) - LIPU_PTR_STEP))
    else $error("Pointer not decremented by one.");
  AST_EMPTY: assert property ( // [R5]
    res == LIPU_RES_EMPTY && !ptr_load_i |=>
      zero_flag_o && ptr == LIPU_PTR_RST && $stable(dest_word_o))
    else $error("Empty pop changed state or missed zero flag.");
  AST_LAST_ONE: assert property ( // [R6]
    res == LIPU_RES_POP && ptr == LIPU_PTR_STEP && !ptr_load_i |=>
      ptr == LIPU_PTR_RST && zero_flag_o)
    else $error("Last pop did not empty the table.");
  AST_OVER_ERR: assert property ( // [R7]
    req && f.wr_ready && !ptr[15] && ptr > len_m1 |=>
      operation_error_flag_o && error_code_word_o == LIPU_ERR_RANGE)
    else $error("Pointer above range not flagged.");
  AST_NEG_ERR: assert property ( // [R8]
    req && f.wr_ready && ptr[15] |=>
      operation_error_flag_o && error_code_word_o == LIPU_ERR_RANGE)
    else $error("Negative pointer not flagged.");
  AST_ERR_STICKY: assert property ( // [R9]
    operation_error_flag_o && !error_clear_i |=> operation_error_flag_o)
    else $error("Error flag dropped without a clear.");
  AST_PULSE_ONCE: assert property ( // [R10]
    take && pulse_mode_i ##1 enable_i && pulse_mode_i |->
      res == LIPU_RES_NONE)
    else $error("Pulse form popped twice in one activation.");
  AST_ENO: assert property ( // [R15]
    !enable_i |=> !execution_state_out_o)
    else $error("Execution state high without enable.");

  COV_POP: cover property (res == LIPU_RES_POP ##1 res == LIPU_RES_POP);
  COV_EMPTY: cover property (res == LIPU_RES_EMPTY);
  COV_ERR: cover property (res == LIPU_RES_ERR);
  COV_STALL: cover property (req && !f.wr_ready);
endmodule
`default_nettype wire

// ===== test/lipu_ctrl_model.sv
// Controller model that issues pop commands and consumes popped words.
`default_nettype none
module lipu_ctrl_model
  import lipu_pkg::*;
(
  // Bench commands.
  input wire logic req_i,
  input wire logic force_i,
  input wire logic stall_i,
  // Pop unit status seen by the program.
  input wire logic [15:0] pointer_i,
  input wire logic [15:0] table_len_i,
  // Commands to the pop unit.
  output logic enable_o,
  output logic out_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Set when the length operand is legal and the pointer in 1..n-1.
  logic range_ok;

  // ==========================================================
  // Range check before each pop.
  // ==========================================================
  // The program only pops a table it knows to be sane; the bench
  // can override this to provoke the unit's own error handling.
  assign range_ok = (table_len_i >= 16'(LIPU_TBL_MIN)) &&
                    (table_len_i <= 16'(LIPU_TBL_MAX)) &&
                    !pointer_i[15] && (pointer_i != 16'h0000) &&
                    (pointer_i < table_len_i);
  assign enable_o = req_i && (force_i || range_ok);
  // The consumer stalls only when told to.
  assign out_ready_o = !stall_i;
endmodule
`default_nettype wire

// ===== test/last_in_pop_unit_bench.sv
// Self-checking bench of the last-in pop unit.
`default_nettype none
module last_in_pop_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lipu_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic en, pm = 0, sw = 0, pl = 0, ec = 0, rdy, vld, zf, ef, ex;
  logic req = 0, frc = 0, stall = 0;
  logic [15:0] len = 16'h0007, wd = 0, plv = 0, od, dst, ptr, code;
  int n_fail = 0;
  int compares = 0;
  // Pointer planted for each error case.
  logic [15:0] bad_ptr;
  // Per pop: pulse form given, then expected dest, pointer and zero flag.
  logic [15:0] rows [4][4] = '{
    '{16'h0000, 16'habcd, 16'h0002, 16'h0000},
    '{16'h0001, 16'h5678, 16'h0001, 16'h0000},
    '{16'h0000, 16'h1234, 16'h0000, 16'h0001},
    '{16'h0001, 16'h1234, 16'h0000, 16'h0001}};

  lipu_pop_unit #(.TABLE_DEPTH(LIPU_TBL_MAX)) dut (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .enable_i(en), .pulse_mode_i(pm),
    .table_len_i(len), .shift_write_entry_i(sw), .write_data_i(wd),
    .ptr_load_i(pl), .ptr_load_value_i(plv), .error_clear_i(ec),
    .out_valid_o(vld), .out_data_o(od), .out_ready_i(rdy),
    .dest_word_o(dst), .pointer_o(ptr), .error_code_word_o(code),
    .zero_flag_o(zf), .operation_error_flag_o(ef),
    .execution_state_out_o(ex));

  lipu_ctrl_model ctrl (.req_i(req), .force_i(frc), .stall_i(stall),
    .pointer_i(ptr), .table_len_i(len), .enable_o(en), .out_ready_o(rdy));

  // ==========================================================
  // Clock and helpers.
  // ==========================================================
  // Half period of 12.5 ns gives 40 MHz.
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Inputs only move at falling edges, away from the sampling edge.
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask

  // Holds the strobe up between writes; the caller lowers it after the last.
  task automatic wr(input logic [15:0] v);
    sw = 1;
    wd = v;
    cyc(1);
  endtask

  task automatic load(input logic [15:0] v);
    pl = 1;
    plv = v;
    cyc(1);
    pl = 0;
  endtask

  // One request; the answer is visible one cycle after the take.
  // An idle cycle follows, so a second call raises the request only
  // after an edge has seen it low; the answer stands through it.
  task automatic pop1();
    req = 1;
    cyc(1);
    req = 0;
    chk(16'(ex), 16'h0001);
    cyc(1);
  endtask

  task automatic give_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_fail++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence.
  // ==========================================================
  initial begin
    cyc(20);
    rst_b_i = 1;
    cyc(3);
    chk(ptr, LIPU_PTR_RST);
    chk(16'({zf, ef, ex, vld}), 16'h0000);
    // Fill three entries, then pop them back last first.
    wr(16'h1234);
    wr(16'h5678);
    wr(16'habcd);
    sw = 0;
    chk(ptr, 16'h0003);
    frc = 1;
    for (int i = 0; i < 4; i++) begin
      pm = rows[i][0][0];
      pop1();
      chk(dst, rows[i][1]);
      chk(ptr, rows[i][2]);
      chk(16'(zf), rows[i][3]);
    end
    pm = 0;
    frc = 0;
    // Ten entries, consumer stalled: only eight pops fit the FIFO.
    len = 16'h0010;
    for (int i = 0; i < 10; i++) begin
      wr(16'h0100 + 16'(i));
    end
    sw = 0;
    stall = 1;
    req = 1;
    cyc(12);
    chk(16'(ex), 16'h0000);
    req = 0;
    cyc(1);
    chk(ptr, 16'h0002);
    stall = 0;
    for (int i = 0; i < 8; i++) begin
      chk(16'(vld), 16'h0001);
      chk(od, 16'h0109 - 16'(i));
      cyc(1);
    end
    // Pulse form pops once however long enable stays high.
    pm = 1;
    req = 1;
    cyc(4);
    req = 0;
    pm = 0;
    cyc(1);
    chk(ptr, 16'h0001);
    // Continuous form pops on every enabled cycle.
    load(16'h0003);
    req = 1;
    cyc(2);
    req = 0;
    cyc(1);
    chk(ptr, 16'h0001);
    // Data words survive pops, so a reload returns the same word.
    load(16'h0002);
    pop1();
    chk(dst, 16'h0101);
    // Pointer at n-1 is still legal.
    len = 16'h000b;
    load(16'h000a);
    pop1();
    chk(dst, 16'h0109);
    chk(16'(ef), 16'h0000);
    // Pointer above n-1, negative pointer, length below two.
    frc = 1;
    for (int i = 0; i < 3; i++) begin
      len = (i == 2) ? 16'h0001 : 16'h0010;
      bad_ptr = (i == 0) ? 16'h0010 : (i == 1) ? 16'hffff : 16'h0001;
      load(bad_ptr);
      pop1();
      chk(16'(ef), 16'h0001);
      chk(code, LIPU_ERR_RANGE);
      chk(ptr, bad_ptr);
      ec = 1;
      cyc(1);
      ec = 0;
      chk(16'(ef), 16'h0000);
    end
    // A new error beats a clear that falls in the same cycle.
    cyc(1);
    ec = 1;
    req = 1;
    cyc(1);
    ec = 0;
    chk(16'(ef), 16'h0001);
    // Mid-run reset with the request held across its release: nothing
    // is taken before the third edge, which then finds an empty table.
    rst_b_i = 0;
    len = 16'h0007;
    cyc(1);
    chk(ptr, LIPU_PTR_RST);
    chk(code, LIPU_WORD_RST);
    chk(16'({zf, ef, ex, vld}), 16'h0000);
    rst_b_i = 1;
    cyc(2);
    chk(16'({zf, ex}), 16'h0000);
    cyc(1);
    chk(16'({zf, ex}), 16'h0003);
    chk(ptr, LIPU_PTR_RST);
    req = 0;
    frc = 0;
    give_verdict();
  end
endmodule
`default_nettype wire
